// [rtl/asl_params.svh]
// register offsets, field positions and reset values of the amplifier status bank
// assumes inclusion by bare name from the design and bench files
`ifndef ASL_PARAMS_SVH
`define ASL_PARAMS_SVH

//----------------------------------------------------------------------
// register indices (printed offsets are not word aligned)
//----------------------------------------------------------------------
`define ASL_IDX_ANALOG_STATUS 8'h4a
`define ASL_IDX_MISC_CONTROL  8'h55
// own registers for interrupt status and mask
`define ASL_IDX_IRQ_STATUS    8'h60
`define ASL_IDX_IRQ_MASK      8'h61

//----------------------------------------------------------------------
// analog status field positions
//----------------------------------------------------------------------
`define ASL_BIT_BAT_LOCKOUT_N 0
`define ASL_BIT_BOOST_OV      1
`define ASL_BIT_OVER_CURRENT  2
`define ASL_BIT_THERMAL       3
`define ASL_BIT_DRV_SHUTDOWN  4
`define ASL_BIT_STAGE_LO      5
`define ASL_BIT_MCLK          9
`define ASL_BIT_PWRUP_RAW     10
`define ASL_BIT_BOOST_ACTIVE  11
`define ASL_BIT_ATTEN_LO      12

// misc control field and reset
`define ASL_BIT_LOOPBACK      0
`define ASL_MISC_RESET        16'h0000
`define ASL_MISC_WMASK        16'h0001

// interrupt events: lockout entry, overvoltage, overcurrent, thermal, shutdown
`define ASL_IRQ_W             5
`define ASL_IRQ_RESET         5'h00

`endif

// [rtl/asl_pkg.sv]
// types shared by the amplifier status bank
// assumes the params header is on the include path
package asl_pkg;
  // ahb data phase bookkeeping
  typedef struct packed {
    logic        pend;   // data phase in progress
    logic        wr;     // pending is a write
    logic [7:0]  idx;    // word index of pending access
  } asl_phase_t;
endpackage : asl_pkg

// [rtl/asl_loop_mux.sv]
// loopback selector between adc decimation output and dac filter input
// assumes both sample streams are synchronous to sys_clk
`timescale 1ns/100ps
`default_nettype none
module asl_loop_mux (
  // control
  input  wire logic        sel,
  // samples
  input  wire logic [23:0] adc_dec_data,
  input  wire logic [23:0] dac_left_data,
  output logic      [23:0] adc_out_data
);
  assign adc_out_data = sel ? dac_left_data : adc_dec_data;
endmodule // asl_loop_mux
`default_nettype wire

// [rtl/asl_regs.sv]
// amplifier status and loopback register bank on an ahb-lite slave
// assumes flag inputs synchronous to sys_clk and a single ahb master
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "asl_params.svh"
module asl_regs (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // status sources
  input  wire logic        battery_lockout_n,
  input  wire logic        boost_overvoltage_flag,
  input  wire logic        over_current_flag,
  input  wire logic        thermal_alarm_flag,
  input  wire logic        driver_shutdown_flag,
  input  wire logic        stage_two_on,
  input  wire logic        stage_three_on,
  input  wire logic        stage_four_on,
  input  wire logic        stage_five_on,
  input  wire logic        master_clock_present,
  input  wire logic        raw_power_up_enable,
  input  wire logic        boost_active,
  input  wire logic        auto_atten_code_b0,
  input  wire logic        auto_atten_code_b1,
  input  wire logic        auto_atten_code_b2,
  // sample path
  input  wire logic [23:0] adc_dec_data,
  input  wire logic [23:0] dac_left_data,
  output logic      [23:0] adc_out_data,
  // control out
  output logic             dac_to_adc_loopback,
  // interrupt
  output logic             irq
);

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  typedef struct packed {
    asl_pkg::asl_phase_t        ph;      // data phase tracking
    logic [15:0]                misc;    // misc control register
    logic [`ASL_IRQ_W-1:0]      ist;     // sticky event bits
    logic [`ASL_IRQ_W-1:0]      imsk;    // interrupt mask
    logic [`ASL_IRQ_W-1:0]      prev;    // event levels last cycle
    logic [31:0]                rdata;   // registered read data
  } asl_state_t;

  asl_state_t st_r;   // registered state
  asl_state_t st_nxt; // next state

  logic [15:0]           status_w;  // live analog status word
  logic [`ASL_IRQ_W-1:0] ev_lvl;    // event levels
  logic [`ASL_IRQ_W-1:0] ev_rise;   // event rising edges
  logic                  addr_ok;   // address phase valid
  logic [31:0]           wmask32;   // misc write mask widened

  // word index from byte address
  function automatic logic [7:0] idx_of(input logic [31:0] a);
    idx_of = a[9:2];
  endfunction

  //--------------------------------------------------------------------
  // live status word
  //--------------------------------------------------------------------
  // status is assembled combinationally and registered at the address phase, so a read sees the level one cycle before its data phase
  always_comb begin
    status_w = 16'h0000;
    status_w[`ASL_BIT_BAT_LOCKOUT_N] = battery_lockout_n;
    status_w[`ASL_BIT_BOOST_OV] = boost_overvoltage_flag;
    status_w[`ASL_BIT_OVER_CURRENT] = over_current_flag;
    status_w[`ASL_BIT_THERMAL] = thermal_alarm_flag;
    status_w[`ASL_BIT_DRV_SHUTDOWN] = driver_shutdown_flag;
    status_w[`ASL_BIT_STAGE_LO +: 4] = {stage_five_on, stage_four_on,
                                        stage_three_on, stage_two_on};
    status_w[`ASL_BIT_MCLK] = master_clock_present;
    status_w[`ASL_BIT_PWRUP_RAW] = raw_power_up_enable;
    status_w[`ASL_BIT_BOOST_ACTIVE] = boost_active;
    status_w[`ASL_BIT_ATTEN_LO +: 3] = {auto_atten_code_b2, auto_atten_code_b1,
                                        auto_atten_code_b0};
  end

  // lockout counts as an event when it goes low
  assign ev_lvl  = {driver_shutdown_flag, thermal_alarm_flag, over_current_flag,
                    boost_overvoltage_flag, ~battery_lockout_n};
  assign ev_rise = ev_lvl & ~st_r.prev;
  assign addr_ok = hsel & hready & htrans[1];
  assign wmask32 = {16'h0000, `ASL_MISC_WMASK};

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = ev_lvl;
    // write data phase completes this cycle
    if (st_r.ph.pend && st_r.ph.wr) begin
      case (st_r.ph.idx)
        `ASL_IDX_MISC_CONTROL: begin
          st_nxt.misc = hwdata[15:0] & wmask32[15:0];
        end
        `ASL_IDX_IRQ_MASK: begin
          st_nxt.imsk = hwdata[`ASL_IRQ_W-1:0];
        end
        `ASL_IDX_IRQ_STATUS: begin
          // write one to clear
          st_nxt.ist = st_r.ist & ~hwdata[`ASL_IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // set beats clear in the same cycle
    st_nxt.ist = st_nxt.ist | ev_rise;
    // address phase: capture and prepare read data
    st_nxt.ph.pend = addr_ok;
    st_nxt.ph.wr   = hwrite;
    st_nxt.ph.idx  = idx_of(haddr);
    st_nxt.rdata   = 32'h0000_0000;
    if (addr_ok && !hwrite) begin
      case (idx_of(haddr))
        `ASL_IDX_ANALOG_STATUS: st_nxt.rdata = {16'h0000, status_w};
        `ASL_IDX_MISC_CONTROL:  st_nxt.rdata = {16'h0000, st_r.misc};
        `ASL_IDX_IRQ_STATUS:    st_nxt.rdata = {27'h0000000, st_nxt.ist};
        `ASL_IDX_IRQ_MASK:      st_nxt.rdata = {27'h0000000, st_r.imsk};
        default:                st_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  //--------------------------------------------------------------------
  // registers
  //--------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r.ph    <= '0;
      st_r.misc  <= `ASL_MISC_RESET;
      st_r.ist   <= `ASL_IRQ_RESET;
      st_r.imsk  <= `ASL_IRQ_RESET;
      st_r.prev  <= '0;
      st_r.rdata <= 32'h0000_0000;
    end else begin
      st_r <= st_nxt;
    end
  end

  //--------------------------------------------------------------------
  // outputs
  //--------------------------------------------------------------------
  assign hrdata    = st_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign irq       = |(st_r.ist & st_r.imsk);
  assign dac_to_adc_loopback = st_r.misc[`ASL_BIT_LOOPBACK];

  asl_loop_mux u_loop (
    .sel           (dac_to_adc_loopback),
    .adc_dec_data  (adc_dec_data),
    .dac_left_data (dac_left_data),
    .adc_out_data  (adc_out_data)
  );

  //--------------------------------------------------------------------
  // assertions: status read-back
  //--------------------------------------------------------------------
  // a status read returns the levels seen at its address phase, so each
  // check holds the data phase against the sources one cycle back
  // lockout bit low
  AST_LOCKOUT_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS && !battery_lockout_n)
      |=> !hrdata[0]) else $error("lockout bit not low");
  AST_OV_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[1] == $past(boost_overvoltage_flag)) else $error("ov bit wrong");
  AST_OC_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[2] == $past(over_current_flag)) else $error("oc bit wrong");
  AST_TH_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[3] == $past(thermal_alarm_flag)) else $error("thermal bit wrong");
  AST_SD_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[4] == $past(driver_shutdown_flag)) else $error("shutdown bit wrong");
  AST_STAGE_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[8:5] == $past({stage_five_on, stage_four_on, stage_three_on,
                                 stage_two_on})) else $error("stage bits wrong");
  AST_MCLK_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[9] == $past(master_clock_present)) else $error("mclk bit wrong");
  AST_BOOST_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[11:10] == $past({boost_active, raw_power_up_enable}))
    else $error("boost bits wrong");
  AST_ATTEN_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_ANALOG_STATUS)
      |=> hrdata[15:12] == $past({1'b0, auto_atten_code_b2, auto_atten_code_b1,
                                   auto_atten_code_b0})) else $error("atten bits wrong");

  AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
    hrdata[31:16] == 16'h0000) else $error("upper read bits set");
  AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && idx_of(haddr) != `ASL_IDX_ANALOG_STATUS
      && idx_of(haddr) != `ASL_IDX_MISC_CONTROL && idx_of(haddr) != `ASL_IDX_IRQ_STATUS
      && idx_of(haddr) != `ASL_IDX_IRQ_MASK) |=> hrdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  // idle cycles carry zero data, so a stale word never looks like an answer
  AST_IDLE_RDATA: assert property (@(posedge sys_clk) disable iff (rst)
    !addr_ok |=> hrdata == 32'h0000_0000) else $error("read data not zero when idle");
  AST_RO_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.ph.pend && st_r.ph.wr && st_r.ph.idx == `ASL_IDX_ANALOG_STATUS)
      |=> $stable(st_r.misc) && $stable(st_r.imsk)) else $error("status write changed state");
  AST_MISC_RSVD: assert property (@(posedge sys_clk) disable iff (rst)
    st_r.misc[15:1] == 15'h0000) else $error("misc reserved bits set");

  //--------------------------------------------------------------------
  // assertions: loopback control
  //--------------------------------------------------------------------
  // loopback routes dac input
  AST_LOOP_PATH: assert property (@(posedge sys_clk) disable iff (rst)
    dac_to_adc_loopback |-> adc_out_data == dac_left_data) else $error("loopback path");
  AST_LOOP_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !dac_to_adc_loopback |-> adc_out_data == adc_dec_data) else $error("normal path");
  AST_LOOP_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.ph.pend && st_r.ph.wr && st_r.ph.idx == `ASL_IDX_MISC_CONTROL)
      |=> dac_to_adc_loopback == $past(hwdata[0])) else $error("loop bit not written");
  AST_LOOP_READ: assert property (@(posedge sys_clk) disable iff (rst)
    (addr_ok && !hwrite && idx_of(haddr) == `ASL_IDX_MISC_CONTROL)
      |=> hrdata[0] == $past(dac_to_adc_loopback)) else $error("loop bit read back");

  //--------------------------------------------------------------------
  // assertions: interrupt events and reset
  //--------------------------------------------------------------------
  // set wins: a clear in the same cycle must not swallow a new event,
  // or software would miss a fault that began while it acknowledged
  AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    (|ev_rise) |=> (st_r.ist & $past(ev_rise)) == $past(ev_rise))
    else $error("event lost");
  // writing one clears the lockout bit when no new lockout edge arrives
  AST_CLEAR_ONE: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.ph.pend && st_r.ph.wr && st_r.ph.idx == `ASL_IDX_IRQ_STATUS && hwdata[0]
      && !ev_rise[0]) |=> !st_r.ist[0]) else $error("lockout event not cleared");
  // mask takes the written value
  AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
    (st_r.ph.pend && st_r.ph.wr && st_r.ph.idx == `ASL_IDX_IRQ_MASK)
      |=> st_r.imsk == $past(hwdata[`ASL_IRQ_W-1:0])) else $error("mask not written");
  // an unmasked event raises the line one cycle later
  AST_IRQ_EVENT: assert property (@(posedge sys_clk) disable iff (rst)
    ((|(ev_rise & st_r.imsk)) && !(st_r.ph.pend && st_r.ph.wr
      && st_r.ph.idx == `ASL_IDX_IRQ_MASK)) |=> irq) else $error("irq not raised");
  // reset leaves control, read data and interrupt quiet
  AST_RESET_CLEAN: assert property (@(posedge sys_clk)
    rst |=> !irq && !dac_to_adc_loopback && hrdata == 32'h0000_0000)
    else $error("state after reset");

endmodule // asl_regs
`default_nettype wire

// [tb/amp_status_and_loopback_regs_tb_top.sv]
// self-checking bench for the amplifier status and loopback register bank
// assumes asl_regs with a zero-wait ahb-lite slave and one 125 MHz clock
`timescale 1ns/100ps
`default_nettype none
`include "asl_params.svh"
module amp_status_and_loopback_regs_tb_top;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        sys_clk = 1'b0;    // 8 ns clock
  logic        rst     = 1'b1;    // sync reset
  logic [31:0] haddr   = 32'h0;   // bus address
  logic [1:0]  htrans  = 2'h0;    // idle at start
  logic        hwrite  = 1'b0;    // direction
  logic [31:0] hwdata  = 32'h0;   // write data
  logic [31:0] hrdata;            // read data
  logic        hreadyout;         // slave ready, fed back as hready
  logic        hresp;             // always okay
  logic [14:0] st      = 15'h0001; // status sources, lsb first
  logic [23:0] adc_dec_data  = 24'h0;
  logic [23:0] dac_left_data = 24'h0;
  logic [23:0] adc_out_data;
  logic        dac_to_adc_loopback;
  logic        irq;
  integer      seed = 43929;      // fixed seed keeps runs repeatable
  int          err_count = 0;
  int          checks_done = 0;
  logic [31:0] rd;
  logic [31:0] wd;

  always #4 sys_clk = ~sys_clk;

  // ---------------------------------------------------------------
  // device under test
  // ---------------------------------------------------------------
  asl_regs DUT (
    .sys_clk(sys_clk), .rst(rst), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .battery_lockout_n(st[0]), .boost_overvoltage_flag(st[1]), .over_current_flag(st[2]),
    .thermal_alarm_flag(st[3]), .driver_shutdown_flag(st[4]), .stage_two_on(st[5]),
    .stage_three_on(st[6]), .stage_four_on(st[7]), .stage_five_on(st[8]),
    .master_clock_present(st[9]), .raw_power_up_enable(st[10]), .boost_active(st[11]),
    .auto_atten_code_b0(st[12]), .auto_atten_code_b1(st[13]), .auto_atten_code_b2(st[14]),
    .adc_dec_data(adc_dec_data), .dac_left_data(dac_left_data), .adc_out_data(adc_out_data),
    .dac_to_adc_loopback(dac_to_adc_loopback), .irq(irq));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte address of a word index; printed offsets are indices
  function automatic logic [31:0] addr(input logic [7:0] idx);
    return {22'h0, idx, 2'b00};
  endfunction

  // status word expected from the source levels, reserved bits zero
  function automatic logic [31:0] exp_stat(input logic [14:0] s);
    return {17'h0, s};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one single transfer; entered just after a rising edge, waits on ready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    // no wait count assumed: only the watchdog ends a stalled transfer
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0, "okay response");
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // watchdog: whole sequence needs well under 2000 cycles
  // ---------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    // reset values of control and interrupt mask registers
    ahb(1'b0, addr(`ASL_IDX_MISC_CONTROL), 32'h0, rd);
    chk(rd, 32'h0, "misc reset");
    ahb(1'b0, addr(`ASL_IDX_IRQ_MASK), 32'h0, rd);
    chk(rd, 32'h0, "mask reset");
    // random sweep with all-zero and all-one corners first
    for (int i = 0; i < 40; i++) begin
      st <= (i == 0) ? 15'h0 : (i == 1) ? 15'h7fff : 15'($random(seed));
      adc_dec_data  <= 24'($random(seed));
      dac_left_data <= 24'($random(seed));
      wd = $random(seed);
      ahb(1'b1, addr(`ASL_IDX_MISC_CONTROL), wd, rd);
      ahb(1'b0, addr(`ASL_IDX_MISC_CONTROL), 32'h0, rd);
      chk(rd, {31'h0, wd[0]}, "misc readback");
      chk({31'h0, dac_to_adc_loopback}, {31'h0, wd[0]}, "loop flag");
      chk({8'h0, adc_out_data}, {8'h0, wd[0] ? dac_left_data : adc_dec_data}, "mux");
      // write attempt to read-only status must not stick
      ahb(1'b1, addr(`ASL_IDX_ANALOG_STATUS), ~wd, rd);
      ahb(1'b0, addr(`ASL_IDX_ANALOG_STATUS), 32'h0, rd);
      chk(rd, exp_stat(st), "status");
      chk({31'h0, irq}, 32'h0, "irq masked");
    end
    // unmapped place reads zero and leaves misc alone
    ahb(1'b1, addr(8'hff), 32'hffff_ffff, rd);
    ahb(1'b0, addr(8'hff), 32'h0, rd);
    chk(rd, 32'h0, "unmapped");
    ahb(1'b0, addr(`ASL_IDX_MISC_CONTROL), 32'h0, rd);
    chk(rd, {31'h0, wd[0]}, "misc kept");
    // interrupt: quiet sources, clear, unmask overvoltage
    st <= 15'h0001;
    repeat (3) @(posedge sys_clk);
    ahb(1'b1, addr(`ASL_IDX_IRQ_STATUS), 32'h1f, rd);
    ahb(1'b1, addr(`ASL_IDX_IRQ_MASK), 32'h02, rd);
    ahb(1'b0, addr(`ASL_IDX_IRQ_STATUS), 32'h0, rd);
    chk(rd, 32'h0, "irq cleared");
    chk({31'h0, irq}, 32'h0, "irq idle");
    // overvoltage and thermal rise
    st <= 15'h000b;
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, addr(`ASL_IDX_IRQ_STATUS), 32'h0, rd);
    chk(rd, 32'h0a, "events latched");
    chk({31'h0, irq}, 32'h1, "irq raised");
    // masking drops the line, status stays
    ahb(1'b1, addr(`ASL_IDX_IRQ_MASK), 32'h0, rd);
    ahb(1'b0, addr(`ASL_IDX_IRQ_MASK), 32'h0, rd);
    chk(rd, 32'h0, "mask cleared");
    chk({31'h0, irq}, 32'h0, "irq masked off");
    // clear one bit with its level still high, then lockout entry
    ahb(1'b1, addr(`ASL_IDX_IRQ_STATUS), 32'h02, rd);
    ahb(1'b1, addr(`ASL_IDX_IRQ_MASK), 32'h1f, rd);
    st <= 15'h000a;
    repeat (3) @(posedge sys_clk);
    ahb(1'b0, addr(`ASL_IDX_IRQ_STATUS), 32'h0, rd);
    chk(rd, 32'h09, "lockout event");
    chk({31'h0, irq}, 32'h1, "irq lockout");
    ahb(1'b1, addr(`ASL_IDX_IRQ_STATUS), 32'h1f, rd);
    ahb(1'b0, addr(`ASL_IDX_IRQ_STATUS), 32'h0, rd);
    chk(rd, 32'h0, "all cleared");
    chk({31'h0, irq}, 32'h0, "irq low");
    // mid-run reset with loopback on and an unmasked over-current pending
    ahb(1'b1, addr(`ASL_IDX_MISC_CONTROL), 32'h1, rd);
    st <= 15'h0005;
    repeat (2) @(posedge sys_clk);
    chk({31'h0, irq}, 32'h1, "irq before reset");
    chk({31'h0, dac_to_adc_loopback}, 32'h1, "loop before reset");
    // quiet sources at release so the edge detector sees no event
    st  <= 15'h0001;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    chk({31'h0, dac_to_adc_loopback}, 32'h0, "loop after reset");
    chk({31'h0, irq}, 32'h0, "irq after reset");
    ahb(1'b0, addr(`ASL_IDX_MISC_CONTROL), 32'h0, rd);
    chk(rd, 32'h0, "misc after reset");
    ahb(1'b0, addr(`ASL_IDX_IRQ_STATUS), 32'h0, rd);
    chk(rd, 32'h0, "events after reset");
    ahb(1'b0, addr(`ASL_IDX_IRQ_MASK), 32'h0, rd);
    chk(rd, 32'h0, "mask after reset");
    ahb(1'b0, addr(`ASL_IDX_ANALOG_STATUS), 32'h0, rd);
    chk(rd, exp_stat(15'h0001), "status after reset");
    end_sim();
  end
endmodule // amp_status_and_loopback_regs_tb_top
`default_nettype wire
